// File: return_and_rotate_exec_bench.sv
/*
 * Self-checking bench for the return and rotate execution core: drives the
 * APB register slave, issues instructions through the instruction register
 * and checks results, flags, pc, shadow restore and the stack pop pulse.
 * Assumes rrx_pkg and rrx_core are compiled first; 200 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec_bench;
	import rrx_pkg::*;

	logic core_clk;
	logic sys_rst;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic stack_pop;
	logic [31:0] rd;
	logic err;
	int miscompares;
	int check_count;
	int pops;

	rrx_core #(.MEM_DEPTH(4096)) uut (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.stack_pop(stack_pop)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (stack_pop === 1'b1) begin
			pops <= pops + 1;
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// pready is read right after the rising edge, before that edge's updates land,
	// so the value seen is the one the edge sampled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) begin
				break;
			end
		end
		if (n == 50) begin
			miscompares++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk({31'h0, err}, 32'h0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, 32'h0);
	endtask

	task automatic mem_set(input logic [11:0] a, input logic [7:0] v);
		wr(OFF_MADDR, {20'h0, a});
		wr(OFF_MDATA, {24'h0, v});
	endtask

	task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
		wr(OFF_MADDR, {20'h0, a});
		rdchk(OFF_MDATA, {24'h0, v});
	endtask

	task automatic rot(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f);
		wr(OFF_INSTR, {16'h0, op, d, a, f});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rdchk(OFF_ACC, 32'h0);
		rdchk(OFF_PC, 32'h0);
		rdchk(OFF_STAT, 32'h0);
		apb(1'b0, 8'h34, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, OFF_PC, 32'h5);
		chk({31'h0, err}, 32'h1);
		rdchk(OFF_PC, 32'h0);
	endtask

	task automatic t_rotates;
		wr(OFF_BANK, 32'h2);
		mem_set(12'h234, 8'he6);
		wr(OFF_FLAGS, 32'h0);
		rot(OPC_RLC, 1'b1, 1'b1, 8'h34);
		mem_chk(12'h234, 8'hcc);
		rdchk(OFF_FLAGS, 32'h5);
		mem_set(12'hf80, 8'he6);
		wr(OFF_ACC, 32'h0);
		wr(OFF_FLAGS, 32'h0);
		rot(OPC_RRC, 1'b0, 1'b0, 8'h80);
		rdchk(OFF_ACC, 32'h73);
		mem_chk(12'hf80, 8'he6);
		rdchk(OFF_FLAGS, 32'h0);
		mem_set(12'hf81, 8'h01);
		rot(OPC_RRC, 1'b1, 1'b0, 8'h81);
		mem_chk(12'hf81, 8'h00);
		rdchk(OFF_FLAGS, 32'h3);
		// carry set beforehand must survive the plain rotate
		mem_set(12'h010, 8'hab);
		wr(OFF_FLAGS, 32'h1);
		rot(OPC_RLN, 1'b1, 1'b0, 8'h10);
		mem_chk(12'h010, 8'h57);
		rdchk(OFF_FLAGS, 32'h1);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_INDEX, 32'h300);
		mem_set(12'h320, 8'h81);
		wr(OFF_FLAGS, 32'h0);
		rot(OPC_RLC, 1'b1, 1'b0, 8'h20);
		mem_chk(12'h320, 8'h02);
		rdchk(OFF_FLAGS, 32'h1);
		mem_set(12'hf60, 8'h40);
		wr(OFF_FLAGS, 32'h0);
		rot(OPC_RLC, 1'b1, 1'b0, 8'h60);
		mem_chk(12'hf60, 8'h80);
		rdchk(OFF_FLAGS, 32'h4);
		wr(OFF_CTRL, 32'h0);
	endtask

	task automatic t_returns;
		int n;
		int p0;
		wr(OFF_STACK, 32'h12345);
		wr(OFF_LATCH, 32'habcd);
		wr(OFF_SHADOW, 32'h00050599);
		wr(OFF_ACC, 32'h11);
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_BANK, 32'h2);
		wr(OFF_STAT, 32'h0);
		p0 = pops;
		wr(OFF_INSTR, 32'h0011);
		for (n = 1; n <= 20; n++) begin
			@(posedge core_clk);
			if (stack_pop === 1'b1) begin
				break;
			end
		end
		chk(32'(n), 32'h5);
		rdchk(OFF_PC, 32'h12345);
		rdchk(OFF_ACC, 32'h99);
		rdchk(OFF_FLAGS, 32'h5);
		rdchk(OFF_BANK, 32'h5);
		rdchk(OFF_STAT, 32'h2);
		rdchk(OFF_LATCH, 32'habcd);
		chk(32'(pops - p0), 32'h1);
		// low-priority enable selected; shadow bit clear keeps acc
		wr(OFF_CTRL, 32'h2);
		wr(OFF_STAT, 32'h0);
		wr(OFF_STACK, 32'h1fffff);
		wr(OFF_ACC, 32'h22);
		wr(OFF_INSTR, 32'h0010);
		rdchk(OFF_PC, 32'h1fffff);
		rdchk(OFF_ACC, 32'h22);
		rdchk(OFF_STAT, 32'h4);
		wr(OFF_STACK, 32'h00abc);
		wr(OFF_FLAGS, 32'h7);
		wr(OFF_INSTR, 32'h0c5a);
		rdchk(OFF_PC, 32'h00abc);
		rdchk(OFF_ACC, 32'h5a);
		rdchk(OFF_FLAGS, 32'h7);
		rdchk(OFF_STAT, 32'h4);
		rdchk(OFF_LATCH, 32'habcd);
		wr(OFF_SHADOW, 32'h00030233);
		wr(OFF_STAT, 32'h0);
		wr(OFF_STACK, 32'h00456);
		p0 = pops;
		wr(OFF_INSTR, 32'h0013);
		rdchk(OFF_PC, 32'h00456);
		rdchk(OFF_ACC, 32'h33);
		rdchk(OFF_FLAGS, 32'h2);
		rdchk(OFF_BANK, 32'h3);
		rdchk(OFF_STAT, 32'h0);
		chk(32'(pops - p0), 32'h1);
		// unknown opcode must be refused with no pop and no pc change
		apb(1'b1, OFF_INSTR, 32'hffff);
		chk({31'h0, err}, 32'h1);
		rdchk(OFF_PC, 32'h00456);
		chk(32'(pops - p0), 32'h1);
	endtask

	// reset in mid-run must bring back the power-up values
	task automatic t_midreset;
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdchk(OFF_PC, 32'h0);
		rdchk(OFF_ACC, 32'h0);
		rdchk(OFF_STAT, 32'h0);
		rdchk(OFF_STACK, 32'h0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		check_count = 0;
		pops = 0;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_rotates();
		t_returns();
		t_midreset();
		complete_run();
	end
endmodule
`default_nettype wire

// File: rrx_core.sv
/*
 * Return and rotate execution core with an APB register slave.
 * Instructions are issued by writing the instruction register; the
 * return stack itself lives outside and only sees a pop pulse.
 * Assumes APB signals are synchronous to core_clk.
 */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rrx_core
	import rrx_pkg::*;
#(
	parameter int MEM_DEPTH = 4096
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic stack_pop
);
	import rrx_pkg::*;

	function automatic rrx_op_e decode_op(input logic [15:0] w);
		decode_op = OP_NONE;
		if (w[15:1] == OPC_IRQ_EXIT) decode_op = OP_IRQ_EXIT;
		else if (w[15:1] == OPC_SUB_EXIT) decode_op = OP_SUB_EXIT;
		else if (w[15:8] == OPC_LIT_EXIT) decode_op = OP_LIT_EXIT;
		else if (w[15:10] == OPC_RLC) decode_op = OP_RLC;
		else if (w[15:10] == OPC_RRC) decode_op = OP_RRC;
		else if (w[15:10] == OPC_RLN) decode_op = OP_RLN;
	endfunction

	function automatic logic is_rot(input rrx_op_e o);
		is_rot = (o == OP_RLC) || (o == OP_RRC) || (o == OP_RLN);
	endfunction

	rrx_state_e state_r;
	rrx_op_e op_r;
	logic [1:0] q_r;
	logic [15:0] instr_r;
	logic [1:0] ctrl_r;
	logic [7:0] acc_r, flags_r, shadow_acc_r, shadow_flags_r;
	logic [BANK_W-1:0] bank_select_reg_r, shadow_bank_select_r;
	logic [PC_W-1:0] pc_r, stack_top_r;
	logic [15:0] prog_latch_r;
	logic [DADDR_W-1:0] index_r, maddr_r, daddr;
	logic [1:0] irq_en_r;
	logic [7:0] operand_r, result_r, mem_rdata, mem_wdata;
	logic carry_r;
	logic pend_r;
	logic apb_go, apb_fire, busy, bad_instr;
	logic core_rd, core_wr, mem_rd, mem_wr;
	logic [7:0] f;
	logic [31:0] rd_mux;
	logic rd_err;

	assign busy = (state_r != S_IDLE);
	assign f = instr_r[7:0];
	assign apb_go = psel && penable && !pready && !pend_r && !busy;
	assign apb_fire = psel && penable && pready;
	assign bad_instr = (decode_op(pwdata[15:0]) == OP_NONE);

	// ------------------------------------------------------------
	// operand address resolution
	// ------------------------------------------------------------
	always_comb begin
		if (instr_r[INS_ABIT]) begin
			daddr = {bank_select_reg_r, f};
		end else if (ctrl_r[CTRL_EXT] && f <= ACCESS_SPLIT) begin
			daddr = DADDR_W'(index_r + {4'h0, f});
		end else if (f <= ACCESS_SPLIT) begin
			daddr = {4'h0, f};
		end else begin
			daddr = {ACCESS_HI_BANK, f};
		end
	end

	// ------------------------------------------------------------
	// data memory port: core owns it while busy, APB otherwise
	// ------------------------------------------------------------
	assign core_rd = (state_r == S_EXEC) && is_rot(op_r) && q_r == Q_READ;
	assign core_wr = (state_r == S_EXEC) && is_rot(op_r) && q_r == Q_LAST && instr_r[INS_DBIT];
	assign mem_rd = core_rd || (apb_go && paddr == OFF_MDATA);
	assign mem_wr = core_wr || (apb_fire && pwrite && paddr == OFF_MDATA && !pslverr);
	assign mem_wdata = core_wr ? result_r : pwdata[7:0];

	rrx_mem #(
		.AW(DADDR_W),
		.DEPTH(MEM_DEPTH)
	) u_mem (
		.core_clk(core_clk),
		.rd_en(mem_rd),
		.wr_en(mem_wr),
		.addr(busy ? daddr : maddr_r),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// ------------------------------------------------------------
	// sequencer: four phases per cycle
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= S_IDLE;
			op_r <= OP_NONE;
			q_r <= 2'h0;
			instr_r <= 16'h0000;
		end else begin
			q_r <= q_r + 2'h1;
			case (state_r)
				S_IDLE: begin
					q_r <= 2'h0;
					if (apb_fire && pwrite && paddr == OFF_INSTR && !pslverr) begin
						instr_r <= pwdata[15:0];
						op_r <= decode_op(pwdata[15:0]);
						state_r <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (q_r == Q_LAST) begin
						state_r <= is_rot(op_r) ? S_IDLE : S_DEAD;
					end
				end
				S_DEAD: begin
					if (q_r == Q_LAST) begin
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// rotate datapath: operand in Q3, result held for Q4
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			operand_r <= RST_BYTE;
			result_r <= RST_BYTE;
			carry_r <= 1'b0;
		end else if (state_r == S_EXEC && q_r == Q_PROC) begin
			operand_r <= mem_rdata;
			case (op_r)
				OP_RLC: begin
					result_r <= {mem_rdata[6:0], flags_r[FLG_C]};
					carry_r <= mem_rdata[7];
				end
				OP_RRC: begin
					result_r <= {flags_r[FLG_C], mem_rdata[7:1]};
					carry_r <= mem_rdata[0];
				end
				OP_RLN: begin
					result_r <= {mem_rdata[6:0], mem_rdata[7]};
					carry_r <= flags_r[FLG_C];
				end
				default: begin
					result_r <= result_r;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// architectural registers, written in Q4 or by APB when idle
	// ------------------------------------------------------------
	logic retire, pop_now;
	assign retire = (state_r == S_EXEC) && q_r == Q_LAST;
	assign pop_now = retire && !is_rot(op_r);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_r <= RST_BYTE;
			flags_r <= RST_BYTE;
			bank_select_reg_r <= '0;
		end else if (retire) begin
			if (is_rot(op_r)) begin
				if (!instr_r[INS_DBIT]) acc_r <= result_r;
				flags_r[FLG_N] <= result_r[7];
				flags_r[FLG_Z] <= (result_r == 8'h00);
				flags_r[FLG_C] <= carry_r;
			end else if (op_r == OP_LIT_EXIT) begin
				acc_r <= instr_r[7:0];
			end else if (instr_r[INS_SHADOW]) begin
				acc_r <= shadow_acc_r;
				flags_r <= shadow_flags_r;
				bank_select_reg_r <= shadow_bank_select_r;
			end
		end else if (apb_fire && pwrite && !pslverr) begin
			if (paddr == OFF_ACC) acc_r <= pwdata[7:0];
			if (paddr == OFF_FLAGS) flags_r <= pwdata[7:0];
			if (paddr == OFF_BANK) bank_select_reg_r <= pwdata[BANK_W-1:0];
		end
	end

	// pc takes the stack top only; the program latches stay as they are
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_r <= RST_PC;
			stack_pop <= 1'b0;
			irq_en_r <= 2'h0;
		end else begin
			stack_pop <= pop_now;
			if (pop_now) begin
				pc_r <= stack_top_r;
			end
			if (pop_now && op_r == OP_IRQ_EXIT) begin
				irq_en_r[ctrl_r[CTRL_LOW]] <= 1'b1;
			end else if (apb_fire && pwrite && paddr == OFF_STAT) begin
				irq_en_r <= pwdata[STAT_IRQL:STAT_IRQH];
			end
		end
	end

	// plain software-owned registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= 2'h0;
			shadow_acc_r <= RST_BYTE;
			shadow_flags_r <= RST_BYTE;
			shadow_bank_select_r <= '0;
			stack_top_r <= RST_PC;
			prog_latch_r <= 16'h0000;
			index_r <= '0;
			maddr_r <= '0;
		end else if (apb_fire && pwrite && !pslverr) begin
			case (paddr)
				OFF_CTRL: ctrl_r <= pwdata[1:0];
				OFF_SHADOW: begin
					shadow_acc_r <= pwdata[7:0];
					shadow_flags_r <= pwdata[SHD_FLAGS+7:SHD_FLAGS];
					shadow_bank_select_r <= pwdata[SHD_BANK+BANK_W-1:SHD_BANK];
				end
				OFF_STACK: stack_top_r <= pwdata[PC_W-1:0];
				OFF_LATCH: prog_latch_r <= pwdata[15:0];
				OFF_INDEX: index_r <= pwdata[DADDR_W-1:0];
				OFF_MADDR: maddr_r <= pwdata[DADDR_W-1:0];
				default: begin
					maddr_r <= maddr_r;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB slave: two wait states, stalls further while executing
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			OFF_CTRL: rd_mux[1:0] = ctrl_r;
			OFF_INSTR: begin
				rd_mux[15:0] = instr_r;
				rd_err = pwrite && bad_instr;
			end
			OFF_STAT: rd_mux[STAT_IRQL:STAT_BUSY] = {irq_en_r, busy};
			OFF_ACC: rd_mux[7:0] = acc_r;
			OFF_FLAGS: rd_mux[7:0] = flags_r;
			OFF_BANK: rd_mux[BANK_W-1:0] = bank_select_reg_r;
			OFF_SHADOW: rd_mux[SHD_BANK+BANK_W-1:0] = {shadow_bank_select_r, shadow_flags_r,
				shadow_acc_r};
			OFF_STACK: rd_mux[PC_W-1:0] = stack_top_r;
			OFF_PC: begin
				rd_mux[PC_W-1:0] = pc_r;
				rd_err = pwrite;
			end
			OFF_LATCH: rd_mux[15:0] = prog_latch_r;
			OFF_INDEX: rd_mux[DADDR_W-1:0] = index_r;
			OFF_MADDR: rd_mux[DADDR_W-1:0] = maddr_r;
			OFF_MDATA: rd_mux[7:0] = mem_rdata;
			default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_r <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pend_r <= apb_go;
			pready <= pend_r;
			if (pend_r) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= rd_err;
			end else if (pready) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ret_dead_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop |-> (state_r == S_DEAD)[*4] ##1 state_r == S_IDLE)
		else $error("return did not idle for one full cycle");
	a_pop_loads_pc: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop |-> pc_r == $past(stack_top_r))
		else $error("pc not loaded from stack top");
	a_latch_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop |-> prog_latch_r == $past(prog_latch_r))
		else $error("program latch changed on return");
	a_irq_enable_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop && op_r == OP_IRQ_EXIT |-> irq_en_r[ctrl_r[CTRL_LOW]])
		else $error("interrupt enable not set on interrupt return");
	a_shadow_restore: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop && op_r != OP_LIT_EXIT |->
		(instr_r[INS_SHADOW] ? (acc_r == $past(shadow_acc_r) && flags_r == $past(shadow_flags_r)
		&& bank_select_reg_r == $past(shadow_bank_select_r))
		: (acc_r == $past(acc_r) && flags_r == $past(flags_r))))
		else $error("shadow restore wrong");
	a_literal_acc: assert property (@(posedge core_clk) disable iff (sys_rst)
		stack_pop && op_r == OP_LIT_EXIT |-> acc_r == instr_r[7:0] && $stable(flags_r))
		else $error("literal return result wrong");
	a_rot_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(state_r == S_EXEC) && is_rot(op_r) |-> ##4 state_r == S_IDLE && !stack_pop)
		else $error("rotate did not finish in one cycle");
	a_rot_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
		retire && is_rot(op_r) |=> flags_r[FLG_N] == result_r[7]
		&& flags_r[FLG_Z] == (result_r == 8'h00))
		else $error("rotate N or Z flag wrong");
	a_rot_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
		retire && op_r == OP_RRC |=> flags_r[FLG_C] == operand_r[0])
		else $error("right rotate carry wrong");
	a_rln_no_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
		retire && op_r == OP_RLN |=> $stable(flags_r[FLG_C]) && result_r[0] == operand_r[7])
		else $error("plain rotate touched carry");
	a_dest_acc: assert property (@(posedge core_clk) disable iff (sys_rst)
		retire && is_rot(op_r) |=> (instr_r[INS_DBIT] ? acc_r == $past(acc_r) : acc_r == result_r))
		else $error("rotate destination wrong");
endmodule
`default_nettype wire

// File: rrx_mem.sv
/*
 * Byte-wide data file memory with registered read data.
 * Assumes one access per cycle; the caller arbitrates ports.
 */
`timescale 1ns/1ps
`default_nettype none
module rrx_mem #(
	parameter int AW = 12,
	parameter int DEPTH = 4096
) (
	input wire logic core_clk,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end
endmodule
`default_nettype wire

// File: rrx_pkg.sv
/*
 * Shared constants for the return and rotate execution block: register map,
 * field positions, reset values, opcode patterns and phase counts.
 * Assumes a 32-bit APB master on the same clock as the core.
 */
package rrx_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSTR = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_ACC = 8'h0c;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_BANK = 8'h14;
	localparam logic [7:0] OFF_SHADOW = 8'h18;
	localparam logic [7:0] OFF_STACK = 8'h1c;
	localparam logic [7:0] OFF_PC = 8'h20;
	localparam logic [7:0] OFF_LATCH = 8'h24;
	localparam logic [7:0] OFF_INDEX = 8'h28;
	localparam logic [7:0] OFF_MADDR = 8'h2c;
	localparam logic [7:0] OFF_MDATA = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_EXT = 0;
	localparam int CTRL_LOW = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_IRQH = 1;
	localparam int STAT_IRQL = 2;
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int SHD_FLAGS = 8;
	localparam int SHD_BANK = 16;
	localparam int INS_SHADOW = 0;
	localparam int INS_ABIT = 8;
	localparam int INS_DBIT = 9;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int PC_W = 21;
	localparam int BANK_W = 4;
	localparam int DADDR_W = 12;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [PC_W-1:0] RST_PC = 21'h000000;

	// ------------------------------------------------------------
	// opcodes and addressing
	// ------------------------------------------------------------
	localparam logic [14:0] OPC_IRQ_EXIT = 15'h0008;
	localparam logic [14:0] OPC_SUB_EXIT = 15'h0009;
	localparam logic [7:0] OPC_LIT_EXIT = 8'h0c;
	localparam logic [5:0] OPC_RLC = 6'h0d;
	localparam logic [5:0] OPC_RRC = 6'h0c;
	localparam logic [5:0] OPC_RLN = 6'h11;
	localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

	// ------------------------------------------------------------
	// timing: four phases per instruction cycle
	// ------------------------------------------------------------
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [1:0] Q_READ = 2'h1;
	localparam logic [1:0] Q_PROC = 2'h2;

	typedef enum {OP_NONE, OP_IRQ_EXIT, OP_SUB_EXIT, OP_LIT_EXIT, OP_RLC, OP_RRC, OP_RLN} rrx_op_e;
	typedef enum {S_IDLE, S_EXEC, S_DEAD} rrx_state_e;

endpackage
